// [design/lsb_regs.sv]
// Converter and low-voltage sink control register bank
`timescale 1ns/100ps

// Contract
// - Bit 3 resets high; high lowers coil current limit by about a third.
// - Bit 4 enables sink A pull-down when pin over 13.75V and converter on.
// - Bit 5 enables the same pull-down for sink B.
// - Bit 6 enables the same pull-down for sink C.
// - Bit 7 low: feedback follows the separate feedback source setting.
// - Bit 7 high: feedback chosen automatically from sinks A and B only.
// - Auto choice needs mode not off and not on the charge pump.
// - Every low-voltage sink uses an 8-bit current code.
// - Code comes from own level or shared flash or torch level.
// - Code is binary weighted, 0.15 mA per lsb up to 38.25 mA.
// - Bit 0 high turns preview off when the strobe time expires.
// - Trigger bits 2:1 reset to 00; 00 off, writing 01 starts preview; after a bit 0 shut-off the code ignores 01 until 00, 10 or 11 is written.
// - High-voltage mode field: off, on, PWM, pattern generator.
// - First low-voltage sink always uses own level when its mode is 11.
module lsb_regs (
  // Clock and reset
  input  wire logic                                   i_clk_sys,
  input  wire logic                                   i_rst_b,
  // Register access
  input  wire lsb_pkg::lsb_reg_req_t                  i_reg_req,
  output logic      [7:0]                             o_reg_rdata,
  output logic                                        o_reg_rvalid,
  // Converter and high-voltage sinks
  input  wire logic                                   i_step_up_on,
  input  wire lsb_pkg::lsb_fb_source_t                i_feedback_source_select,
  input  wire lsb_pkg::lsb_hv_sink_t [lsb_pkg::NUM_HV_SINKS-1:0] i_hv_sink,
  output logic                                        o_coil_limit_reduced,
  output logic                                        o_gain_select,
  output logic                                        o_skip_fast,
  output logic                                        o_fb_pin_protect,
  output logic      [lsb_pkg::NUM_HV_SINKS-1:0]       o_hv_pull_down,
  output lsb_pkg::lsb_fb_source_t                     o_feedback_source,
  // Low-voltage sink group
  input  wire logic [1:0]                             i_lv_sink_first_mode,
  input  wire logic [lsb_pkg::NUM_LV_SINKS-1:0][lsb_pkg::LEVEL_W-1:0] i_lv_sink_level,
  input  wire logic [lsb_pkg::SHARED_W-1:0]           i_shared_flash_level,
  input  wire logic [lsb_pkg::SHARED_W-1:0]           i_shared_torch_level,
  input  wire logic                                   i_strobe_active,
  input  wire logic                                   i_strobe_expired,
  output logic      [lsb_pkg::NUM_LV_SINKS-1:0][lsb_pkg::LEVEL_W-1:0] o_lv_sink_code,
  output logic                                        o_preview_active
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_b;
  logic rst_sync_b;

  // Two flops so release is clean against the clock
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] boost_converter_ctrl_two;
  logic [7:0] converter_sink_protect_ctrl;
  logic       wr_boost;
  logic       wr_protect;
  logic [1:0] wr_trig;

  // Address decode
  always_comb begin
    wr_boost   = 1'b0;
    wr_protect = 1'b0;
    if (i_reg_req.wr && (i_reg_req.addr == lsb_pkg::ADDR_BOOST_CTRL_TWO)) begin
      wr_boost = 1'b1;
    end else if (i_reg_req.wr && (i_reg_req.addr == lsb_pkg::ADDR_SINK_PROTECT_CTRL)) begin
      wr_protect = 1'b1;
    end
  end

  assign wr_trig = i_reg_req.wdata[lsb_pkg::BIT_TRIG_HI:lsb_pkg::BIT_TRIG_LO];

  always_ff @(posedge i_clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      boost_converter_ctrl_two <= lsb_pkg::RST_BOOST_CTRL_TWO;
    end else if (wr_boost) begin
      boost_converter_ctrl_two <= i_reg_req.wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      converter_sink_protect_ctrl <= lsb_pkg::RST_SINK_PROTECT_CTRL;
    end else if (wr_protect) begin
      converter_sink_protect_ctrl <= i_reg_req.wdata & lsb_pkg::PROTECT_CTRL_USED;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] next_reg_rdata;

  // Unmapped addresses answer zero rather than stalling
  always_comb begin
    if (i_reg_req.addr == lsb_pkg::ADDR_BOOST_CTRL_TWO) begin
      next_reg_rdata = boost_converter_ctrl_two;
    end else if (i_reg_req.addr == lsb_pkg::ADDR_SINK_PROTECT_CTRL) begin
      next_reg_rdata = converter_sink_protect_ctrl;
    end else begin
      next_reg_rdata = lsb_pkg::READ_UNMAPPED;
    end
  end

  // Read data held until the next read
  always_ff @(posedge i_clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      o_reg_rdata  <= lsb_pkg::READ_UNMAPPED;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_req.rd;
      if (i_reg_req.rd) begin
        o_reg_rdata <= next_reg_rdata;
      end
    end
  end

  // ****************************************
  // Converter controls
  // ****************************************
  logic [lsb_pkg::NUM_HV_SINKS-1:0] ovp_enable;
  logic [lsb_pkg::NUM_HV_SINKS-1:0] next_hv_pull_down;

  assign ovp_enable = {boost_converter_ctrl_two[lsb_pkg::BIT_HV_C_OVP],
                       boost_converter_ctrl_two[lsb_pkg::BIT_HV_B_OVP],
                       boost_converter_ctrl_two[lsb_pkg::BIT_HV_A_OVP]};

  genvar gh;
  generate
    for (gh = 0; gh < lsb_pkg::NUM_HV_SINKS; gh++) begin : g_clamp
      assign next_hv_pull_down[gh] = ovp_enable[gh] & i_step_up_on & i_hv_sink[gh].over_threshold;
    end
  endgenerate

  // Static converter settings and sink pull-downs
  always_ff @(posedge i_clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      o_coil_limit_reduced <= lsb_pkg::RST_BOOST_CTRL_TWO[lsb_pkg::BIT_COIL_LOWCUR];
      o_gain_select        <= lsb_pkg::RST_BOOST_CTRL_TWO[lsb_pkg::BIT_GAIN_SELECT];
      o_skip_fast          <= lsb_pkg::RST_BOOST_CTRL_TWO[lsb_pkg::BIT_SKIP_FAST];
      o_fb_pin_protect     <= lsb_pkg::RST_BOOST_CTRL_TWO[lsb_pkg::BIT_FB_PIN_PROT];
      o_hv_pull_down       <= '0;
    end else begin
      o_coil_limit_reduced <= boost_converter_ctrl_two[lsb_pkg::BIT_COIL_LOWCUR];
      o_gain_select        <= boost_converter_ctrl_two[lsb_pkg::BIT_GAIN_SELECT];
      o_skip_fast          <= boost_converter_ctrl_two[lsb_pkg::BIT_SKIP_FAST];
      o_fb_pin_protect     <= boost_converter_ctrl_two[lsb_pkg::BIT_FB_PIN_PROT];
      o_hv_pull_down       <= next_hv_pull_down;
    end
  end

  // ****************************************
  // Feedback selection
  // ****************************************
  logic                    elig_a;
  logic                    elig_b;
  lsb_pkg::lsb_fb_source_t next_feedback_source;

  assign elig_a = (i_hv_sink[0].hv_sink_mode_field != lsb_pkg::MODE_OFF) &
                  !i_hv_sink[0].sink_on_charge_pump_flag;
  assign elig_b = (i_hv_sink[1].hv_sink_mode_field != lsb_pkg::MODE_OFF) &
                  !i_hv_sink[1].sink_on_charge_pump_flag;

  // Sink A preferred when both qualify; no candidate leaves the loop open
  always_comb begin
    if (!boost_converter_ctrl_two[lsb_pkg::BIT_FB_AUTO]) begin
      next_feedback_source = i_feedback_source_select;
    end else if (elig_a) begin
      next_feedback_source = lsb_pkg::LSB_FB_SINK_A;
    end else if (elig_b) begin
      next_feedback_source = lsb_pkg::LSB_FB_SINK_B;
    end else begin
      next_feedback_source = lsb_pkg::LSB_FB_NONE;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      o_feedback_source <= lsb_pkg::LSB_FB_PIN;
    end else begin
      o_feedback_source <= next_feedback_source;
    end
  end

  // ****************************************
  // Preview control
  // ****************************************
  lsb_pkg::lsb_preview_state_t pv_state;
  lsb_pkg::lsb_preview_state_t next_pv_state;

  // Locked state ignores re-writes of 01 so a stale torch cannot restart
  always_comb begin
    next_pv_state = pv_state;
    case (pv_state)
      lsb_pkg::LSB_PV_OFF: begin
        if (wr_protect && (wr_trig == lsb_pkg::TRIG_SOFT)) begin
          next_pv_state = lsb_pkg::LSB_PV_ON;
        end
      end
      lsb_pkg::LSB_PV_ON: begin
        if (wr_protect && (wr_trig != lsb_pkg::TRIG_SOFT)) begin
          next_pv_state = lsb_pkg::LSB_PV_OFF;
        end else if (i_strobe_expired &&
                     converter_sink_protect_ctrl[lsb_pkg::BIT_PREVIEW_OFF_AFTER]) begin
          next_pv_state = lsb_pkg::LSB_PV_LOCKED;
        end
      end
      lsb_pkg::LSB_PV_LOCKED: begin
        if (wr_protect && (wr_trig != lsb_pkg::TRIG_SOFT)) begin
          next_pv_state = lsb_pkg::LSB_PV_OFF;
        end
      end
      default: begin
        next_pv_state = lsb_pkg::LSB_PV_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pv_state <= lsb_pkg::LSB_PV_OFF;
    end else begin
      pv_state <= next_pv_state;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      o_preview_active <= 1'b0;
    end else begin
      o_preview_active <= (next_pv_state == lsb_pkg::LSB_PV_ON);
    end
  end

  // ****************************************
  // Low-voltage sink codes
  // ****************************************
  logic [lsb_pkg::NUM_LV_SINKS-1:0][lsb_pkg::LEVEL_W-1:0] next_lv_sink_code;
  logic [lsb_pkg::NUM_LV_SINKS-1:0]                       use_own;
  logic                                                   preview_on;

  assign preview_on = (pv_state == lsb_pkg::LSB_PV_ON);

  genvar gl;
  generate
    for (gl = 0; gl < lsb_pkg::NUM_LV_SINKS; gl++) begin : g_lv
      if (gl == 0) begin : g_first
        assign use_own[gl] = (i_lv_sink_first_mode == lsb_pkg::FIRST_MODE_OWN);
      end else begin : g_rest
        assign use_own[gl] = 1'b0;
      end
      lsb_level_select u_sel (
        .i_use_own            (use_own[gl]),
        .i_strobe_active      (i_strobe_active),
        .i_preview_active     (preview_on),
        .i_own_level          (i_lv_sink_level[gl]),
        .i_shared_flash_level (i_shared_flash_level),
        .i_shared_torch_level (i_shared_torch_level),
        .o_level              (next_lv_sink_code[gl])
      );
    end
  endgenerate

  // weighted code passed unchanged to the DAC
  always_ff @(posedge i_clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      o_lv_sink_code <= '0;
    end else begin
      o_lv_sink_code <= next_lv_sink_code;
    end
  end

endmodule

// [design/lsb_pkg.sv]
// Shared constants and types for the sink and converter control registers
package lsb_pkg;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] ADDR_SINK_PROTECT_CTRL = 8'h12; // converter_sink_protect_ctrl
  localparam logic [7:0] ADDR_BOOST_CTRL_TWO    = 8'h22; // boost_converter_ctrl_two
  localparam logic [7:0] RST_SINK_PROTECT_CTRL  = 8'h00;
  localparam logic [7:0] RST_BOOST_CTRL_TWO     = 8'h0c; // Protect and low-current bits set
  localparam logic [7:0] READ_UNMAPPED          = 8'h00;

  // ****************************************
  // Field positions, boost_converter_ctrl_two
  // ****************************************
  localparam int BIT_GAIN_SELECT   = 0;
  localparam int BIT_SKIP_FAST     = 1;
  localparam int BIT_FB_PIN_PROT   = 2;
  localparam int BIT_COIL_LOWCUR   = 3;
  localparam int BIT_HV_A_OVP      = 4;
  localparam int BIT_HV_B_OVP      = 5;
  localparam int BIT_HV_C_OVP      = 6;
  localparam int BIT_FB_AUTO       = 7;

  // ****************************************
  // Field positions, converter_sink_protect_ctrl
  // ****************************************
  localparam int BIT_PREVIEW_OFF_AFTER = 0;
  localparam int BIT_TRIG_LO           = 1;
  localparam int BIT_TRIG_HI           = 2;
  localparam logic [7:0] PROTECT_CTRL_USED = 8'h07; // Bits 7:3 read as zero

  // ****************************************
  // Codes and widths
  // ****************************************
  localparam int NUM_HV_SINKS = 3;
  localparam int NUM_LV_SINKS = 4;
  localparam int LEVEL_W      = 8;
  localparam int SHARED_W     = 6;
  localparam int SHARED_SHIFT = 2;   // 0.6 mA step onto the 0.15 mA weighted code
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_ON      = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_PATTERN = 2'h3;
  localparam logic [1:0] TRIG_OFF     = 2'h0;
  localparam logic [1:0] TRIG_SOFT    = 2'h1;
  localparam logic [1:0] FIRST_MODE_OWN = 2'h3;

  // Preview control states, Gray along off -> on -> locked
  typedef enum logic [1:0] {
    LSB_PV_OFF    = 2'h0,
    LSB_PV_ON     = 2'h1,
    LSB_PV_LOCKED = 2'h3
  } lsb_preview_state_t;

  // Converter feedback source
  typedef enum logic [1:0] {
    LSB_FB_PIN    = 2'h0,
    LSB_FB_SINK_A = 2'h1,
    LSB_FB_SINK_B = 2'h2,
    LSB_FB_NONE   = 2'h3
  } lsb_fb_source_t;

  // Status of one high-voltage sink
  typedef struct packed {
    logic [1:0] hv_sink_mode_field;
    logic       sink_on_charge_pump_flag;
    logic       over_threshold;          // Pin above the 13.75 V clamp level
  } lsb_hv_sink_t;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsb_reg_req_t;

endpackage

// [design/lsb_level_select.sv]
// Current code selection for one low-voltage sink
`timescale 1ns/100ps

module lsb_level_select (
  // Selection
  input  wire logic                             i_use_own,
  input  wire logic                             i_strobe_active,
  input  wire logic                             i_preview_active,
  // Levels
  input  wire logic [lsb_pkg::LEVEL_W-1:0]      i_own_level,
  input  wire logic [lsb_pkg::SHARED_W-1:0]     i_shared_flash_level,
  input  wire logic [lsb_pkg::SHARED_W-1:0]     i_shared_torch_level,
  // Result
  output logic      [lsb_pkg::LEVEL_W-1:0]      o_level
);

  logic [lsb_pkg::LEVEL_W-1:0] flash_code;
  logic [lsb_pkg::LEVEL_W-1:0] torch_code;

  // Shared codes scaled onto the binary weighted 8-bit code
  assign flash_code = {i_shared_flash_level, {lsb_pkg::SHARED_SHIFT{1'b0}}};
  assign torch_code = {i_shared_torch_level, {lsb_pkg::SHARED_SHIFT{1'b0}}};

  always_comb begin
    if (i_use_own) begin
      o_level = i_own_level;
    end else if (i_strobe_active) begin
      o_level = flash_code;
    end else if (i_preview_active) begin
      o_level = torch_code;
    end else begin
      o_level = i_own_level;
    end
  end

endmodule

// [test/lsb_regs_chk.sv]
// Assertion checker for the sink and converter control registers
`timescale 1ns/100ps

module lsb_regs_chk (
  // Clock and reset
  input wire logic                              i_clk_sys,
  input wire logic                              i_rst_b,
  // Register access and converter side
  input wire lsb_pkg::lsb_reg_req_t             i_reg_req,
  input wire logic                              i_step_up_on,
  input wire lsb_pkg::lsb_hv_sink_t [lsb_pkg::NUM_HV_SINKS-1:0] i_hv_sink,
  input wire logic                              o_coil_limit_reduced,
  input wire logic [lsb_pkg::NUM_HV_SINKS-1:0]  o_hv_pull_down,
  input wire lsb_pkg::lsb_fb_source_t           o_feedback_source,
  // Low-voltage sink side
  input wire logic [1:0]                        i_lv_sink_first_mode,
  input wire logic [lsb_pkg::NUM_LV_SINKS-1:0][lsb_pkg::LEVEL_W-1:0] i_lv_sink_level,
  input wire logic [lsb_pkg::SHARED_W-1:0]      i_shared_flash_level,
  input wire logic                              i_strobe_active,
  input wire logic [lsb_pkg::NUM_LV_SINKS-1:0][lsb_pkg::LEVEL_W-1:0] o_lv_sink_code,
  input wire logic                              o_preview_active
);
  // ********************
  // Helper logic
  // ********************
  logic [1:0] up_cnt;
  logic       rdy;
  logic       w22;
  logic       w12;

  // Ignore the two-flop window while the internal reset copy still holds
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end

  // Decoded writes
  assign rdy = (up_cnt == 2'h3);
  assign w22 = rdy && i_reg_req.wr && (i_reg_req.addr == lsb_pkg::ADDR_BOOST_CTRL_TWO);
  assign w12 = rdy && i_reg_req.wr && (i_reg_req.addr == lsb_pkg::ADDR_SINK_PROTECT_CTRL);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // Auto write followed by two quiet cycles on the same register
  sequence s_auto_write;
    w22 && i_reg_req.wdata[7] ##1 (!w22) [*2];
  endsequence

  // ********************
  // Assertions
  // ********************
  a_coil_limit_follows: assert property (
    w22 |-> ##2 o_coil_limit_reduced == $past(i_reg_req.wdata[3], 2)) else $error("coil limit not updated");
  a_pulldown_needs_on: assert property (
    !i_step_up_on |=> o_hv_pull_down == 3'h0) else $error("pull-down with converter off");
  a_pulldown_b_over: assert property (
    !i_hv_sink[1].over_threshold |=> !o_hv_pull_down[1]) else $error("sink b pull-down below threshold");
  a_pulldown_c_cause: assert property (
    o_hv_pull_down[2] |-> $past(i_hv_sink[2].over_threshold && i_step_up_on)) else $error("sink c pull-down uncaused");
  a_auto_never_pin: assert property (
    s_auto_write |=> o_feedback_source != lsb_pkg::LSB_FB_PIN) else $error("auto feedback chose pin");
  a_trigger_off_write: assert property (
    w12 && i_reg_req.wdata[2:1] != lsb_pkg::TRIG_SOFT |=> !o_preview_active) else $error("preview stayed on");
  a_flash_code_shared: assert property (
    rdy && i_strobe_active |=> o_lv_sink_code[1] == {$past(i_shared_flash_level), 2'b00})
    else $error("flash code wrong");
  a_first_own_level: assert property (
    rdy && i_lv_sink_first_mode == 2'h3 |=> o_lv_sink_code[0] == $past(i_lv_sink_level[0]))
    else $error("first sink level wrong");
endmodule

bind lsb_regs lsb_regs_chk u_chk (.i_clk_sys, .i_rst_b, .i_reg_req, .i_step_up_on, .i_hv_sink,
  .o_coil_limit_reduced, .o_hv_pull_down, .o_feedback_source, .i_lv_sink_first_mode, .i_lv_sink_level,
  .i_shared_flash_level, .i_strobe_active, .o_lv_sink_code, .o_preview_active);

// [test/lsb_regs_bench.sv]
// Self-checking bench for the sink and converter control registers
`timescale 1ns/100ps

module lsb_regs_bench;
  // ********************
  // Signals
  // ********************
  logic                        clk;
  logic                        rst_b;
  lsb_pkg::lsb_reg_req_t       req;
  logic [7:0]                  rdata;
  logic                        rvalid;
  logic                        step_on;
  lsb_pkg::lsb_fb_source_t     fb_sel;
  lsb_pkg::lsb_hv_sink_t [2:0] hv;
  logic                        coil;
  logic [2:0]                  lo;
  logic [2:0]                  pd;
  lsb_pkg::lsb_fb_source_t     fb;
  logic [1:0]                  first_mode;
  logic [3:0][7:0]             own;
  logic [5:0]                  flash;
  logic [5:0]                  torch;
  logic                        strobe;
  logic                        expired;
  logic [3:0][7:0]             code;
  logic                        pv;
  int                          n_fail;
  int                          n_compared;

  lsb_regs dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_step_up_on(step_on), .i_feedback_source_select(fb_sel), .i_hv_sink(hv),
    .o_coil_limit_reduced(coil), .o_gain_select(lo[0]), .o_skip_fast(lo[1]), .o_fb_pin_protect(lo[2]),
    .o_hv_pull_down(pd), .o_feedback_source(fb), .i_lv_sink_first_mode(first_mode),
    .i_lv_sink_level(own), .i_shared_flash_level(flash), .i_shared_torch_level(torch),
    .i_strobe_active(strobe), .i_strobe_expired(expired), .o_lv_sink_code(code), .o_preview_active(pv));

  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Registered outputs trail a write by up to two edges, so wait three
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    repeat (3) @(negedge clk);
  endtask

  // Valid is a one-cycle pulse, looked at right after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    chk({7'h00, rvalid}, 8'h01, "read valid");
    chk(rdata, exp, "read data");
  endtask

  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  task automatic strobe_pulse;
    strobe = 1'b1;
    settle;
    chk(code[2], {flash, 2'b00}, "strobe code");
    expired = 1'b1;
    @(negedge clk);
    expired = 1'b0;
    strobe = 1'b0;
    settle;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset_and_map;
    chk({7'h00, coil}, 8'h01, "coil after reset");
    chk({5'h00, lo}, 8'h04, "low bits after reset");
    rd(lsb_pkg::ADDR_BOOST_CTRL_TWO, 8'h0c);
    rd(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'h00);
    wr(8'h13, 8'hff);
    rd(8'h13, 8'h00);
    wr(lsb_pkg::ADDR_BOOST_CTRL_TWO, 8'h00);
    chk({7'h00, coil}, 8'h00, "normal limit");
    chk({5'h00, lo}, 8'h00, "low bits cleared");
    wr(lsb_pkg::ADDR_BOOST_CTRL_TWO, 8'h07);
    chk({5'h00, lo}, 8'h07, "low bits set");
    wr(lsb_pkg::ADDR_BOOST_CTRL_TWO, 8'h08);
    chk({7'h00, coil}, 8'h01, "reduced limit");
  endtask

  task automatic t_overvoltage;
    step_on = 1'b1;
    for (int n = 0; n < 3; n++) begin
      hv[n].over_threshold = 1'b1;
    end
    for (int n = 0; n < 3; n++) begin
      wr(lsb_pkg::ADDR_BOOST_CTRL_TWO, 8'(8'h10 << n));
      chk({5'h00, pd}, 8'(8'h01 << n), "pull-down enable");
      hv[n].over_threshold = 1'b0;
      settle;
      chk({5'h00, pd}, 8'h00, "below threshold");
      hv[n].over_threshold = 1'b1;
    end
    wr(lsb_pkg::ADDR_BOOST_CTRL_TWO, 8'h70);
    chk({5'h00, pd}, 8'h07, "all pull-downs");
    step_on = 1'b0;
    settle;
    chk({5'h00, pd}, 8'h00, "converter off");
  endtask

  task automatic t_feedback;
    wr(lsb_pkg::ADDR_BOOST_CTRL_TWO, 8'h08);
    for (int s = 0; s < 4; s++) begin
      fb_sel = lsb_pkg::lsb_fb_source_t'(s);
      settle;
      chk({6'h00, fb}, 8'(s), "manual feedback");
    end
    fb_sel = lsb_pkg::LSB_FB_PIN;
    hv[1].hv_sink_mode_field = lsb_pkg::MODE_ON;
    wr(lsb_pkg::ADDR_BOOST_CTRL_TWO, 8'h88);
    for (int m = 0; m < 4; m++) begin
      hv[0].hv_sink_mode_field = 2'(m);
      settle;
      chk({6'h00, fb}, (m == 0) ? 8'h02 : 8'h01, "auto feedback mode");
    end
    hv[0].sink_on_charge_pump_flag = 1'b1;
    hv[2].hv_sink_mode_field = lsb_pkg::MODE_ON;
    settle;
    chk({6'h00, fb}, 8'h02, "sink a on pump");
    hv[1].sink_on_charge_pump_flag = 1'b1;
    settle;
    chk({6'h00, fb}, 8'h03, "none eligible");
  endtask

  task automatic t_preview;
    wr(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'h02);
    chk({7'h00, pv}, 8'h01, "soft trigger");
    chk(code[3], {torch, 2'b00}, "torch code");
    strobe_pulse;
    chk({7'h00, pv}, 8'h01, "normal after strobe");
    for (int c = 2; c < 4; c++) begin
      wr(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'(c << 1));
      chk({7'h00, pv}, 8'h00, "unused trigger code");
      chk(code[3], own[3], "own code");
      wr(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'h02);
    end
    wr(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'h03);
    strobe_pulse;
    chk({7'h00, pv}, 8'h00, "off after strobe");
    wr(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'h03);
    chk({7'h00, pv}, 8'h00, "locked");
    wr(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'h01);
    wr(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'hfb);
    chk({7'h00, pv}, 8'h01, "restarted");
    rd(lsb_pkg::ADDR_SINK_PROTECT_CTRL, 8'h03);
  endtask

  task automatic t_first_sink;
    first_mode = lsb_pkg::FIRST_MODE_OWN;
    settle;
    chk(code[0], own[0], "first sink own");
    first_mode = 2'h0;
    settle;
    chk(code[0], {torch, 2'b00}, "first sink torch");
  endtask

  // ********************
  // Clock, run and verdict
  // ********************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence, all inputs start defined
  initial begin
    rst_b = 1'b0;
    req = '0;
    step_on = 1'b0;
    fb_sel = lsb_pkg::LSB_FB_PIN;
    hv = '0;
    first_mode = 2'h0;
    own = {8'hff, 8'h81, 8'h42, 8'h3c};
    flash = 6'h2a;
    torch = 6'h15;
    strobe = 1'b0;
    expired = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset_and_map;
    t_overvoltage;
    t_feedback;
    t_preview;
    t_first_sink;
    finish_test;
  end

  // Run needs well under 1000 cycles
  initial begin
    #20000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test;
  end
endmodule
